/* File: hw/upsm_power_state_manager.sv */
// Purpose: Power state sequencing of a USB attached network device
// Assumes: clk_i is the free 200 MHz domain; USB and MAC events
//          arrive on clk_i; bus power, pin reset and pins are async
// Notes: Register port answers reads one cycle after the strobe
//
// Overview of operation
// RQ1 - POR without bus power stays absent
// RQ2 - Bus power loss forces absent state
// RQ3 - Four ways into NORMAL
// RQ4 - Any system reset lands in Unconfigured
// RQ5 - Configuration completes: Configured, all modules on
// RQ6 - Deconfigure returns to Unconfigured
// RQ7 - Ready in NORMAL, after configuration load
// RQ8 - Context kept, ready on suspend return
// RQ9 - Suspend enters level from selection field
// RQ10 - Level defaults deepest, reverts on deconfigure
// RQ11 - Resume or enabled wake leaves suspend
// RQ12 - Unconfigured suspend only deepest, returns Unconfigured
// RQ13 - Bus reset or pin reset reinitialise
// RQ14 - Wol level wakes on LAN, pins
// RQ15 - Energy level wakes on energy, pins
// RQ16 - Deepest wakes by host or pin only
// RQ17 - Clocked level keeps clocks, frame wakes
// RQ18 - Clocked level: LAN enables drop frames
// RQ19 - LAN cause bit covers good frames
// RQ20 - Link select stays readable for pin 7
// RQ21 - PLL gated in low power states
// RQ22 - Host clears pending wakes before suspend
// RQ23 - Level latched when suspend is detected
module upsm_power_state_manager #(
    parameter int PIN_COUNT = 11
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Asynchronous pins
    input wire logic bus_power_detect_i,
    input wire logic pin_reset_n_i,
    input wire logic [PIN_COUNT-1:0] pin_i,
    // USB controller and wake sources
    input wire upsm_pkg::upsm_usb_s usb_i,
    input wire upsm_pkg::upsm_wake_s wake_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    // Power controls and status
    output logic pll_enable_o,
    output logic full_enable_o,
    output logic phy_power_down_o,
    output logic frame_drop_o,
    output logic ready_o,
    output logic remote_wake_o,
    output upsm_pkg::upsm_state_e state_o
);

    localparam int SW = PIN_COUNT + 2;

    // Pin synchroniser: three stages, accepted when stage 2 and 3 agree
    logic [SW-1:0] sync1_q;
    logic [SW-1:0] sync2_q;
    logic [SW-1:0] sync3_q;
    logic [SW-1:0] clean_q;
    logic [SW-1:0] clean_rst;
    logic vbus;
    logic pin_rst_n;
    logic [PIN_COUNT-1:0] pins;

    // Registers and state
    upsm_pkg::upsm_state_e state_q;
    upsm_pkg::upsm_state_e state_d;
    logic from_conf_q;
    logic [1:0] level_q;
    logic lan_en_q;
    logic energy_en_q;
    logic [upsm_pkg::LAN_CTL_W-1:0] lan_ctl_q;
    logic [PIN_COUNT-1:0] pin_en_q;
    logic link_sel_q;
    logic [PIN_COUNT-1:0] pin_flags_q;
    logic [PIN_COUNT-1:0] pin_flags_d;
    logic [1:0] cause_q;
    logic [1:0] cause_d;
    logic load_pending_q;
    logic ready_q;
    logic remote_wake_q;
    logic [31:0] rdata_q;

    // Decoded terms
    logic sys_rst;
    logic in_sleep;
    logic lan_hit;
    logic energy_hit;
    logic wake_hit;
    logic [PIN_COUNT-1:0] pin_set;
    logic wr_pm;
    logic wr_lan;
    logic wr_pin;
    logic wr_flags;

    function automatic upsm_pkg::upsm_state_e level_state(
        input logic [1:0] lvl
    );
        upsm_pkg::upsm_state_e s;
        unique case (lvl)
            upsm_pkg::LVL_WOL: s = upsm_pkg::ST_SLEEP_WOL;
            upsm_pkg::LVL_ENERGY: s = upsm_pkg::ST_SLEEP_ENERGY;
            upsm_pkg::LVL_DEEPEST: s = upsm_pkg::ST_SLEEP_DEEPEST;
            upsm_pkg::LVL_CLOCKED: s = upsm_pkg::ST_SLEEP_CLOCKED;
        endcase
        return s;
    endfunction

    function automatic logic is_normal(input upsm_pkg::upsm_state_e s);
        return s == upsm_pkg::ST_UNCONF || s == upsm_pkg::ST_CONF;
    endfunction

    assign clean_rst = {1'b0, upsm_pkg::RST_PIN_RESET_N,
                        {PIN_COUNT{1'b0}}};

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            sync1_q <= clean_rst;
            sync2_q <= clean_rst;
            sync3_q <= clean_rst;
            clean_q <= clean_rst;
        end
        else
        begin
            sync1_q <= {bus_power_detect_i, pin_reset_n_i, pin_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < SW; i++)
            begin
                if (sync2_q[i] == sync3_q[i])
                begin
                    clean_q[i] <= sync3_q[i];
                end
            end
        end
    end

    assign vbus = clean_q[SW-1];
    assign pin_rst_n = clean_q[SW-2];
    assign pins = clean_q[PIN_COUNT-1:0];

    // Soft system reset from pin or USB bus
    assign sys_rst = !pin_rst_n || usb_i.bus_reset; // [RQ13]

    assign in_sleep = !is_normal(state_q) &&
                      state_q != upsm_pkg::ST_VBUS_ABSENT;

    // Wake event qualification per level
    always_comb
    begin
        pin_set = pins & pin_en_q; // [RQ14] [RQ15] [RQ16]
        if (link_sel_q && wake_i.phy_link_up &&
            (state_q == upsm_pkg::ST_SLEEP_WOL ||
             state_q == upsm_pkg::ST_SLEEP_CLOCKED))
        begin
            pin_set[upsm_pkg::PIN_LINK] = 1'b1; // [RQ17] [RQ20]
        end
        lan_hit = 1'b0;
        if (state_q == upsm_pkg::ST_SLEEP_WOL)
        begin
            lan_hit = lan_en_q && wake_i.mac_wol; // [RQ14]
        end
        if (state_q == upsm_pkg::ST_SLEEP_CLOCKED)
        begin
            // LAN enable is ignored; frames only pass with no LAN enables
            lan_hit = wake_i.good_frame && !(|lan_ctl_q); // [RQ17] [RQ18]
        end
        energy_hit = state_q == upsm_pkg::ST_SLEEP_ENERGY &&
                     energy_en_q && wake_i.phy_energy; // [RQ15]
        // Pending flags wake again at once after suspend
        wake_hit = in_sleep && (lan_hit || energy_hit || |pin_set ||
                   |pin_flags_q || |cause_q); // [RQ11] [RQ22]
    end

    assign frame_drop_o = state_q == upsm_pkg::ST_SLEEP_CLOCKED &&
                          |lan_ctl_q; // [RQ18]

    // Next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            upsm_pkg::ST_VBUS_ABSENT:
            begin
                if (vbus)
                begin
                    state_d = upsm_pkg::ST_UNCONF; // [RQ1] [RQ3]
                end
            end
            upsm_pkg::ST_UNCONF:
            begin
                if (usb_i.configured)
                begin
                    state_d = upsm_pkg::ST_CONF; // [RQ5]
                end
                else if (usb_i.suspend)
                begin
                    state_d = upsm_pkg::ST_SLEEP_DEEPEST; // [RQ12]
                end
            end
            upsm_pkg::ST_CONF:
            begin
                if (usb_i.deconfigured)
                begin
                    state_d = upsm_pkg::ST_UNCONF; // [RQ6]
                end
                else if (usb_i.suspend)
                begin
                    state_d = level_state(level_q); // [RQ9] [RQ23]
                end
            end
            upsm_pkg::ST_SLEEP_WOL,
            upsm_pkg::ST_SLEEP_ENERGY,
            upsm_pkg::ST_SLEEP_DEEPEST,
            upsm_pkg::ST_SLEEP_CLOCKED:
            begin
                if (usb_i.resume || wake_hit)
                begin
                    state_d = from_conf_q ? upsm_pkg::ST_CONF
                                          : upsm_pkg::ST_UNCONF; // [RQ3] [RQ8] [RQ12]
                end
            end
            default:
            begin
                state_d = upsm_pkg::ST_VBUS_ABSENT;
            end
        endcase
        if (sys_rst)
        begin
            state_d = upsm_pkg::ST_UNCONF; // [RQ3] [RQ4] [RQ13]
        end
        if (!vbus)
        begin
            state_d = upsm_pkg::ST_VBUS_ABSENT; // [RQ1] [RQ2]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_q <= upsm_pkg::ST_VBUS_ABSENT; // [RQ1]
            from_conf_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == upsm_pkg::ST_CONF && !in_sleep)
            begin
                from_conf_q <= 1'b1;
            end
            else if (!in_sleep)
            begin
                from_conf_q <= 1'b0;
            end
        end
    end

    // Ready: in NORMAL once the configuration load has finished
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            load_pending_q <= upsm_pkg::RST_LOAD_PENDING;
            ready_q <= 1'b0;
        end
        else
        begin
            if (usb_i.load_done)
            begin
                load_pending_q <= 1'b0;
            end
            else if (sys_rst)
            begin
                load_pending_q <= 1'b1; // [RQ7]
            end
            ready_q <= is_normal(state_d) &&
                       (usb_i.load_done || !load_pending_q) &&
                       !sys_rst; // [RQ7] [RQ8]
        end
    end

    // Remote wake pulse when a wake event ends suspend
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            remote_wake_q <= 1'b0;
        end
        else
        begin
            remote_wake_q <= wake_hit && !usb_i.resume &&
                             is_normal(state_d);
        end
    end

    assign wr_pm = reg_write_i && reg_addr_i == upsm_pkg::OFS_POWER_MGMT;
    assign wr_lan = reg_write_i && reg_addr_i == upsm_pkg::OFS_LAN_WAKE;
    assign wr_pin = reg_write_i && reg_addr_i == upsm_pkg::OFS_PIN_WAKE;
    assign wr_flags = reg_write_i && reg_addr_i == upsm_pkg::OFS_PIN_FLAGS;

    // Control registers, reinitialised by any system reset
    always_ff @(posedge clk_i)
    begin
        if (reset_i || sys_rst)
        begin
            level_q <= upsm_pkg::RST_LEVEL; // [RQ10] [RQ13]
            lan_en_q <= 1'b0;
            energy_en_q <= 1'b0;
            lan_ctl_q <= '0;
            pin_en_q <= '0;
            link_sel_q <= 1'b0;
        end
        else
        begin
            if (usb_i.deconfigured && state_q == upsm_pkg::ST_CONF)
            begin
                level_q <= upsm_pkg::RST_LEVEL; // [RQ10]
            end
            else if (wr_pm)
            begin
                level_q <= reg_wdata_i[upsm_pkg::PM_LEVEL_LO +: 2]; // [RQ9]
            end
            if (wr_pm)
            begin
                lan_en_q <= reg_wdata_i[upsm_pkg::PM_LAN_EN];
                energy_en_q <= reg_wdata_i[upsm_pkg::PM_ENERGY_EN];
            end
            if (wr_lan)
            begin
                lan_ctl_q <= reg_wdata_i[upsm_pkg::LAN_CTL_W-1:0];
            end
            if (wr_pin)
            begin
                pin_en_q <= reg_wdata_i[PIN_COUNT-1:0];
                link_sel_q <= reg_wdata_i[upsm_pkg::PW_LINK_SEL]; // [RQ20]
            end
        end
    end

    // Sticky wake flags, write one to clear, a new event wins
    always_comb
    begin
        pin_flags_d = pin_flags_q;
        cause_d = cause_q;
        if (wr_flags)
        begin
            pin_flags_d = pin_flags_q & ~reg_wdata_i[PIN_COUNT-1:0];
        end
        if (wr_pm)
        begin
            cause_d = cause_q &
                      ~reg_wdata_i[upsm_pkg::PM_CAUSE_LAN +: 2];
        end
        if (in_sleep)
        begin
            pin_flags_d = pin_flags_d | pin_set;
            cause_d[0] = cause_d[0] | lan_hit; // [RQ19]
            cause_d[1] = cause_d[1] | energy_hit;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i || sys_rst)
        begin
            pin_flags_q <= '0;
            cause_q <= '0;
        end
        else
        begin
            pin_flags_q <= pin_flags_d;
            cause_q <= cause_d;
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= '0;
            if (reg_read_i)
            begin
                unique case (reg_addr_i)
                    upsm_pkg::OFS_POWER_MGMT:
                    begin
                        rdata_q[upsm_pkg::PM_READY] <= ready_q;
                        rdata_q[upsm_pkg::PM_LEVEL_LO +: 2] <= level_q;
                        rdata_q[upsm_pkg::PM_LAN_EN] <= lan_en_q;
                        rdata_q[upsm_pkg::PM_ENERGY_EN] <= energy_en_q;
                        rdata_q[upsm_pkg::PM_CAUSE_LAN +: 2] <= cause_q;
                        rdata_q[upsm_pkg::PM_CONFIGURED] <= from_conf_q ||
                            state_q == upsm_pkg::ST_CONF;
                        rdata_q[upsm_pkg::PM_STATE_LO +: 3] <= state_q;
                        rdata_q[upsm_pkg::PM_PLL_ON] <= pll_enable_o;
                    end
                    upsm_pkg::OFS_LAN_WAKE:
                    begin
                        rdata_q[upsm_pkg::LAN_CTL_W-1:0] <= lan_ctl_q;
                    end
                    upsm_pkg::OFS_PIN_WAKE:
                    begin
                        rdata_q[PIN_COUNT-1:0] <= pin_en_q;
                        rdata_q[upsm_pkg::PW_LINK_SEL] <= link_sel_q; // [RQ20]
                    end
                    upsm_pkg::OFS_PIN_FLAGS:
                    begin
                        rdata_q[PIN_COUNT-1:0] <= pin_flags_q;
                    end
                    default:
                    begin
                        rdata_q <= '0;
                    end
                endcase
            end
        end
    end

    // Clock and module gating: reference clock itself is never gated
    assign pll_enable_o = state_q == upsm_pkg::ST_UNCONF ||
                          state_q == upsm_pkg::ST_CONF ||
                          state_q == upsm_pkg::ST_SLEEP_CLOCKED; // [RQ21] [RQ17]
    assign full_enable_o = state_q == upsm_pkg::ST_CONF; // [RQ4] [RQ5]
    assign phy_power_down_o = state_q == upsm_pkg::ST_SLEEP_DEEPEST; // [RQ16]
    assign ready_o = ready_q;
    assign remote_wake_o = remote_wake_q;
    assign reg_rdata_o = rdata_q;
    assign state_o = state_q;

endmodule

/* File: shared/upsm_pkg.sv */
// Purpose: Shared constants and types of the USB power state manager
// Assumes: 32-bit register port, byte offsets
// Notes: Used by hardware and bench
package upsm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_POWER_MGMT = 8'h00;
    localparam logic [7:0] OFS_LAN_WAKE = 8'h04;
    localparam logic [7:0] OFS_PIN_WAKE = 8'h08;
    localparam logic [7:0] OFS_PIN_FLAGS = 8'h0C;

    // power_mgmt_control fields
    localparam int PM_READY = 0;
    localparam int PM_LEVEL_LO = 1;
    localparam int PM_LAN_EN = 3;
    localparam int PM_ENERGY_EN = 4;
    localparam int PM_CAUSE_LAN = 5;
    localparam int PM_CAUSE_ENERGY = 6;
    localparam int PM_CONFIGURED = 7;
    localparam int PM_STATE_LO = 8;
    localparam int PM_PLL_ON = 11;

    // pin wake and LAN wake register fields
    localparam int PW_LINK_SEL = 16;
    localparam int PIN_LINK = 7;
    localparam int LAN_CTL_W = 5;

    // Sleep level encodings
    localparam logic [1:0] LVL_WOL = 2'h0;
    localparam logic [1:0] LVL_ENERGY = 2'h1;
    localparam logic [1:0] LVL_DEEPEST = 2'h2;
    localparam logic [1:0] LVL_CLOCKED = 2'h3;

    // Values after reset
    localparam logic [1:0] RST_LEVEL = LVL_DEEPEST;
    localparam logic RST_PIN_RESET_N = 1'b1;
    localparam logic RST_LOAD_PENDING = 1'b1;

    typedef enum logic [2:0] {
        ST_VBUS_ABSENT,
        ST_UNCONF,
        ST_CONF,
        ST_SLEEP_WOL,
        ST_SLEEP_ENERGY,
        ST_SLEEP_DEEPEST,
        ST_SLEEP_CLOCKED
    } upsm_state_e;

    // USB controller events, one-cycle pulses
    typedef struct packed {
        logic bus_reset;
        logic suspend;
        logic resume;
        logic configured;
        logic deconfigured;
        logic load_done;
    } upsm_usb_s;

    // MAC and PHY wake sources, same clock
    typedef struct packed {
        logic mac_wol;
        logic phy_energy;
        logic phy_link_up;
        logic good_frame;
    } upsm_wake_s;

endpackage

/* File: bench/upsm_props.sv */
// Purpose: Port checks of the power state manager
// Assumes: async pins lag through the synchroniser
// Notes: quiet_q marks bus power and pin reset settled
module upsm_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Watched inputs
    input wire logic bus_power_detect_i,
    input wire logic pin_reset_n_i,
    input wire upsm_pkg::upsm_usb_s usb_i,
    // Watched outputs
    input wire logic pll_enable_o,
    input wire logic full_enable_o,
    input wire logic phy_power_down_o,
    input wire logic frame_drop_o,
    input wire logic ready_o,
    input wire logic remote_wake_o,
    input wire upsm_pkg::upsm_state_e state_o
);
    logic [2:0] quiet_q;
    logic quiet;
    logic sleeping;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    always_ff @(posedge clk_i)
    begin
        if (reset_i || !bus_power_detect_i || !pin_reset_n_i)
            quiet_q <= 3'h0;
        else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
    end
    assign quiet = quiet_q == 3'h7;
    assign sleeping = state_o >= upsm_pkg::ST_SLEEP_WOL;

    property p_pll;
        pll_enable_o == (state_o inside {upsm_pkg::ST_UNCONF,
            upsm_pkg::ST_CONF, upsm_pkg::ST_SLEEP_CLOCKED});
    endproperty
    a_pll: assert property (p_pll)
        else $error("pll enable wrong");
    property p_full;
        full_enable_o == (state_o == upsm_pkg::ST_CONF);
    endproperty
    a_full: assert property (p_full)
        else $error("full enable wrong");
    property p_phy_down;
        phy_power_down_o == (state_o == upsm_pkg::ST_SLEEP_DEEPEST);
    endproperty
    a_phy_down: assert property (p_phy_down)
        else $error("phy power down wrong");
    property p_unconf_sleep;
        quiet && state_o == upsm_pkg::ST_UNCONF && usb_i.suspend
            && !usb_i.bus_reset |=> state_o == upsm_pkg::ST_SLEEP_DEEPEST;
    endproperty
    a_unconf_sleep: assert property (p_unconf_sleep)
        else $error("unconfigured suspend not deepest");
    property p_deconf;
        quiet && state_o == upsm_pkg::ST_CONF && usb_i.deconfigured
            && !usb_i.bus_reset && !usb_i.suspend
            |=> state_o == upsm_pkg::ST_UNCONF;
    endproperty
    a_deconf: assert property (p_deconf)
        else $error("deconfigure not unconfigured");
    property p_resume;
        quiet && sleeping && usb_i.resume && !usb_i.bus_reset
            |=> state_o inside {upsm_pkg::ST_UNCONF, upsm_pkg::ST_CONF};
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume missed normal");
    property p_soft_reset;
        quiet && usb_i.bus_reset && state_o != upsm_pkg::ST_VBUS_ABSENT
            |=> state_o == upsm_pkg::ST_UNCONF;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("bus reset not unconfigured");
    property p_absent;
        (!bus_power_detect_i) [*8] |=> state_o == upsm_pkg::ST_VBUS_ABSENT;
    endproperty
    a_absent: assert property (p_absent)
        else $error("no bus power but not absent");
    property p_ready;
        ready_o |-> state_o inside {upsm_pkg::ST_UNCONF, upsm_pkg::ST_CONF};
    endproperty
    a_ready: assert property (p_ready)
        else $error("ready outside normal");
    property p_wake_pulse;
        remote_wake_o |-> $past(state_o) >= upsm_pkg::ST_SLEEP_WOL
            && !sleeping ##1 !remote_wake_o;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("stray remote wake");
    property p_frame_drop;
        frame_drop_o |-> state_o == upsm_pkg::ST_SLEEP_CLOCKED;
    endproperty
    a_frame_drop: assert property (p_frame_drop)
        else $error("stray frame drop");

    c_drop: cover property (frame_drop_o);
    c_wake: cover property (remote_wake_o && state_o == upsm_pkg::ST_CONF);
    c_back: cover property (phy_power_down_o ##1 state_o == upsm_pkg::ST_UNCONF);
endmodule

bind upsm_power_state_manager upsm_props upsm_props_inst (
    .clk_i(clk_i), .reset_i(reset_i),
    .bus_power_detect_i(bus_power_detect_i),
    .pin_reset_n_i(pin_reset_n_i), .usb_i(usb_i),
    .pll_enable_o(pll_enable_o), .full_enable_o(full_enable_o),
    .phy_power_down_o(phy_power_down_o), .frame_drop_o(frame_drop_o),
    .ready_o(ready_o), .remote_wake_o(remote_wake_o), .state_o(state_o)
);

/* File: bench/upsm_host_model.sv */
// Purpose: USB host side, sends controller event pulses
// Assumes: each event is a one-cycle pulse on clk_i
// Notes: registers are set before send
module upsm_host_model (
    // Clock
    input wire logic clk_i,
    // Event pulses
    output upsm_pkg::upsm_usb_s usb_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial usb_o = '0;

    // Caller sets level and clears wakes first
    task automatic send(input logic [5:0] e);
        @(posedge clk_i);
        usb_o <= e;
        @(posedge clk_i);
        usb_o <= '0;
    endtask
endmodule

/* File: bench/test_usb_power_state_manager.sv */
// Purpose: Self-checking bench of the power state manager
// Assumes: 200 MHz clock, sync active high reset
// Notes: sleep levels from a table, odd cases by hand
module test_usb_power_state_manager;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [5:0] EV_BRST = 6'h20;
    localparam logic [5:0] EV_SUSP = 6'h10;
    localparam logic [5:0] EV_RES = 6'h08;
    localparam logic [5:0] EV_CONF = 6'h04;
    localparam logic [5:0] EV_DECONF = 6'h02;
    localparam logic [5:0] EV_LOAD = 6'h01;

    typedef struct packed {
        logic [1:0] lvl;
        logic [3:0] w;
        upsm_pkg::upsm_state_e st;
        logic [1:0] cause;
    } upsm_row_s;

    logic clk_i, reset_i, bus_power_detect_i, pin_reset_n_i;
    logic [10:0] pin_i;
    upsm_pkg::upsm_usb_s usb;
    upsm_pkg::upsm_wake_s wake_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, d;
    logic reg_write_i, reg_read_i, pll_enable_o, full_enable_o;
    logic phy_power_down_o, frame_drop_o, ready_o, remote_wake_o;
    upsm_pkg::upsm_state_e state_o;
    int miscompares = 0;
    int checked = 0;
    upsm_row_s rows [4] = '{
        '{upsm_pkg::LVL_WOL, 4'h8, upsm_pkg::ST_SLEEP_WOL, 2'h1},
        '{upsm_pkg::LVL_ENERGY, 4'h4, upsm_pkg::ST_SLEEP_ENERGY, 2'h2},
        '{upsm_pkg::LVL_DEEPEST, 4'h0, upsm_pkg::ST_SLEEP_DEEPEST, 2'h0},
        '{upsm_pkg::LVL_CLOCKED, 4'h1, upsm_pkg::ST_SLEEP_CLOCKED, 2'h1}
    };

    upsm_host_model upsm_host_model_inst (.clk_i(clk_i), .usb_o(usb));

    upsm_power_state_manager upsm_power_state_manager_inst (
        .clk_i(clk_i), .reset_i(reset_i),
        .bus_power_detect_i(bus_power_detect_i),
        .pin_reset_n_i(pin_reset_n_i), .pin_i(pin_i),
        .usb_i(usb), .wake_i(wake_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .pll_enable_o(pll_enable_o),
        .full_enable_o(full_enable_o), .phy_power_down_o(phy_power_down_o),
        .frame_drop_o(frame_drop_o), .ready_o(ready_o),
        .remote_wake_o(remote_wake_o), .state_o(state_o)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask

    task automatic ev(input logic [5:0] e);
        upsm_host_model_inst.send(e);
        #1;
    endtask

    task automatic wait_st(input upsm_pkg::upsm_state_e st);
        for (int i = 0; i < 40 && state_o !== st; i++)
        begin
            @(posedge clk_i);
            #1;
        end
        chk(32'(state_o), 32'(st));
    endtask

    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    initial
    begin
        #(20000 * 5);
        miscompares++;
        conclude();
    end

    initial
    begin
        reset_i = 1'b1;
        bus_power_detect_i = 1'b0;
        pin_reset_n_i = 1'b1;
        pin_i = '0;
        wake_i = '0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        reg_write_i = 1'b0;
        reg_read_i = 1'b0;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        #1 chk(32'(state_o), 32'(upsm_pkg::ST_VBUS_ABSENT));
        rd(8'h00, d);
        chk(d & 32'h0000_0007, 32'h0000_0004);
        bus_power_detect_i <= 1'b1;
        wait_st(upsm_pkg::ST_UNCONF);
        ev(EV_LOAD);
        chk(32'(ready_o), 32'h1);
        $display("test power_up finished");

        wr(8'h00, 32'h0000_007E);
        ev(EV_SUSP);
        chk(32'(state_o), 32'(upsm_pkg::ST_SLEEP_DEEPEST));
        ev(EV_RES);
        chk(32'(state_o), 32'(upsm_pkg::ST_UNCONF));
        chk(32'(ready_o), 32'h1);
        ev(EV_CONF);
        chk(32'(full_enable_o), 32'h1);
        $display("test unconfigured_sleep finished");

        foreach (rows[i])
        begin
            wr(8'h00, 32'h0000_0078 | {29'h0, rows[i].lvl, 1'b0});
            ev(EV_SUSP);
            chk(32'(state_o), 32'(rows[i].st));
            @(posedge clk_i);
            wake_i <= rows[i].w;
            #1;
            if (rows[i].w == 4'h0)
                ev(EV_RES);
            wait_st(upsm_pkg::ST_CONF);
            chk(32'(remote_wake_o), 32'(rows[i].w != 4'h0));
            chk(32'(ready_o), 32'h1);
            wake_i <= '0;
            rd(8'h00, d);
            chk(d & 32'h0000_0066,
                {25'h0, rows[i].cause, 2'h0, rows[i].lvl, 1'b0});
        end
        $display("test sleep_levels finished");

        wr(8'h00, 32'h0000_007C);
        ev(EV_SUSP);
        @(posedge clk_i);
        wake_i <= 4'h8;
        repeat (20) @(posedge clk_i);
        #1 chk(32'(state_o), 32'(upsm_pkg::ST_SLEEP_DEEPEST));
        wake_i <= '0;
        ev(EV_RES);
        wr(8'h04, 32'h0000_0001);
        wr(8'h00, 32'h0000_007E);
        wr(8'h08, 32'h0001_0000);
        wr(8'h0C, 32'h0000_07FF);
        ev(EV_SUSP);
        chk(32'(frame_drop_o), 32'h1);
        @(posedge clk_i);
        wake_i <= 4'h1;
        repeat (10) @(posedge clk_i);
        #1 chk(32'(state_o), 32'(upsm_pkg::ST_SLEEP_CLOCKED));
        wake_i <= 4'h2;
        wait_st(upsm_pkg::ST_CONF);
        wake_i <= '0;
        rd(8'h08, d);
        chk(d & 32'h0001_0000, 32'h0001_0000);
        wr(8'h04, 32'h0000_0000);
        wr(8'h08, 32'h0000_0000);
        wr(8'h0C, 32'h0000_07FF);
        $display("test clocked_filters finished");

        wr(8'h00, 32'h0000_007A);
        ev(EV_DECONF);
        chk(32'(state_o), 32'(upsm_pkg::ST_UNCONF));
        rd(8'h00, d);
        chk(d & 32'h0000_0006, 32'h0000_0004);
        ev(EV_CONF);
        wr(8'h08, 32'h0000_0001);
        ev(EV_SUSP);
        chk(32'(state_o), 32'(upsm_pkg::ST_SLEEP_DEEPEST));
        @(posedge clk_i);
        pin_i <= 11'h001;
        wait_st(upsm_pkg::ST_CONF);
        pin_i <= '0;
        wr(8'h08, 32'h0000_0000);
        wr(8'h0C, 32'h0000_07FF);
        $display("test pin_wake finished");

        ev(EV_SUSP);
        ev(EV_BRST);
        chk(32'(state_o), 32'(upsm_pkg::ST_UNCONF));
        chk(32'(ready_o), 32'h0);
        ev(EV_LOAD);
        chk(32'(ready_o), 32'h1);
        ev(EV_SUSP);
        @(posedge clk_i);
        pin_reset_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        pin_reset_n_i <= 1'b1;
        #1 wait_st(upsm_pkg::ST_UNCONF);
        rd(8'h10, d);
        chk(d, 32'h0000_0000);
        $display("test resets finished");

        @(posedge clk_i);
        bus_power_detect_i <= 1'b0;
        #1 wait_st(upsm_pkg::ST_VBUS_ABSENT);
        chk(32'(ready_o), 32'h0);
        $display("test power_loss finished");
        conclude();
    end
endmodule
